// ===== core/vrf_relay_config.sv
/*
  Function configuration of a combined over/undervoltage relay: the two
  switchgroups, stage conditioning, output contact drive and the breaker
  failure backup timer.
  Assumes stage signals and measurement flags come from logic on sys_clk;
  the binary unlatch input is an asynchronous pin.
*/
// Notes on behaviour
// - Latch switch 0 releases output with the trip; 1 holds until unlatched.
// - Panel, binary input or serial bus unlatch releases a latched power output.
// - Signal output minimum pulse is 80 ms for 0, 40 ms for 1.
// - Power output minimum pulse is 80 ms for 0, 40 ms for 1.
// - A latched power output overrides its minimum pulse timing.
// - Backup on: output a starts timer; uncleared fault at delay drives output b.
// - Phase switch 0 selects three-phase, 1 single-phase measuring.
// - Second undervoltage uses conventional measurement for 0, positive sequence for 1.
// - Conventional mode: 0 needs all phases low, 1 any phase low.
// - First undervoltage blocked below 0.2 rated when its switch is 0.
// - Second undervoltage blocked below 0.2 rated when its switch is 0.
// - Second overvoltage stage fully inhibited when its switch is 1.
// - Second undervoltage stage fully inhibited when its switch is 1.
// - Trip-block switch 1 blocks first undervoltage trip by its own start.
// - Each group reports checksum of positions weighted 1 to 128.
`timescale 1ns/1ps
module vrf_relay_config
  import vrf_pkg::*;
#(
  parameter int MS_DIV = VRF_MS_DIV
) (
  input wire logic sys_clk,
  input wire logic nrst,
  // Switchgroup access from the serial bus or front panel
  input wire logic cfg_wr_en,
  input wire logic cfg_wr_sel,
  input wire logic [7:0] cfg_wr_data,
  output logic [7:0] output_function_switches,
  output logic [7:0] stage_function_switches,
  output logic [7:0] output_checksum,
  output logic [7:0] stage_checksum,
  // Unlatch requests
  input wire logic unlatch_panel,
  input wire logic unlatch_serial,
  input wire logic unlatch_binary_pin,
  // Breaker failure delay in milliseconds
  input wire logic [9:0] breaker_failure_delay_ms,
  // Protection stage side
  input wire vrf_stage_t stage_in,
  input wire vrf_meas_t meas_in,
  output logic single_phase_mode,
  output logic uv2_use_pos_seq,
  output vrf_stage_t stage_out,
  // Output contacts
  output logic power_output_a,
  output logic power_output_b,
  output logic signal_output_a,
  output logic signal_output_b,
  output logic breaker_failure_backup
);

  // ----------------------------------------------------------------
  // Switchgroup storage
  // ----------------------------------------------------------------
  logic [7:0] next_output_sw;
  logic [7:0] next_stage_sw;

  // Unused output switches are masked at write, so they can never be set
  assign next_output_sw = (cfg_wr_en && (cfg_wr_sel == VRF_SEL_OUTPUT)) ?
                          (cfg_wr_data & VRF_OUTPUT_USED_MASK) :
                          output_function_switches;
  assign next_stage_sw = (cfg_wr_en && (cfg_wr_sel == VRF_SEL_STAGE)) ?
                         cfg_wr_data : stage_function_switches;

  // Both groups reset to all switches off
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      output_function_switches <= VRF_OUTPUT_RESET;
      stage_function_switches <= VRF_STAGE_RESET;
    end else begin
      output_function_switches <= next_output_sw;
      stage_function_switches <= next_stage_sw;
    end
  end

  // ----------------------------------------------------------------
  // Checksums
  // ----------------------------------------------------------------
  // Weighted sum of positions with weights 1..128
  function automatic logic [7:0] vrf_checksum(input logic [7:0] sw);
    logic [7:0] sum;
    sum = 8'h00;
    for (int i = 0; i < 8; i++) begin
      sum = sum + (sw[i] ? 8'(1 << i) : 8'h00);
    end
    return sum;
  endfunction : vrf_checksum

  // Registered so the reported sum is stable for the reader
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      output_checksum <= 8'h00;
      stage_checksum <= 8'h00;
    end else begin
      output_checksum <= vrf_checksum(next_output_sw);
      stage_checksum <= vrf_checksum(next_stage_sw);
    end
  end

  // ----------------------------------------------------------------
  // Switch decode
  // ----------------------------------------------------------------
  logic latch_a;
  logic latch_b;
  logic sig_short;
  logic pwr_short;
  logic backup_en;
  logic sw_single;
  logic sw_pos_seq;
  logic sw_any_phase;
  logic sw_uv1_noblk;
  logic sw_uv2_noblk;
  logic sw_ov2_inh;
  logic sw_uv2_inh;
  logic sw_uv1_tripblk;

  assign latch_a = output_function_switches[VRF_OF_LATCH_A];
  assign latch_b = output_function_switches[VRF_OF_LATCH_B];
  assign sig_short = output_function_switches[VRF_OF_SIG_SHORT];
  assign pwr_short = output_function_switches[VRF_OF_PWR_SHORT];
  assign backup_en = output_function_switches[VRF_OF_BACKUP_EN];
  assign sw_single = stage_function_switches[VRF_SF_SINGLE_PHASE];
  assign sw_pos_seq = stage_function_switches[VRF_SF_POS_SEQ];
  assign sw_any_phase = stage_function_switches[VRF_SF_ANY_PHASE];
  assign sw_uv1_noblk = stage_function_switches[VRF_SF_UV1_NOBLK];
  assign sw_uv2_noblk = stage_function_switches[VRF_SF_UV2_NOBLK];
  assign sw_ov2_inh = stage_function_switches[VRF_SF_OV2_INHIBIT];
  assign sw_uv2_inh = stage_function_switches[VRF_SF_UV2_INHIBIT];
  assign sw_uv1_tripblk = stage_function_switches[VRF_SF_UV1_TRIPBLK];

  // ----------------------------------------------------------------
  // Stage conditioning
  // ----------------------------------------------------------------
  logic uv1_blocked;
  logic uv2_blocked;
  logic uv2_conv_low;
  logic uv2_low;
  vrf_stage_t next_stage;

  // Low-voltage blocking keeps undervoltage stages quiet on a dead line
  assign uv1_blocked = meas_in.low_voltage & ~sw_uv1_noblk;
  assign uv2_blocked = meas_in.low_voltage & ~sw_uv2_noblk;
  // Single-phase use sees only the first phase input
  assign uv2_conv_low = sw_single ? meas_in.phase_below[0] :
                        sw_any_phase ? (|meas_in.phase_below) :
                        (&meas_in.phase_below);
  assign uv2_low = sw_pos_seq ? meas_in.pos_seq_below : uv2_conv_low;

  assign next_stage.ov1_start = stage_in.ov1_start;
  assign next_stage.ov1_trip = stage_in.ov1_trip;
  assign next_stage.ov2_start = stage_in.ov2_start & ~sw_ov2_inh;
  assign next_stage.ov2_trip = stage_in.ov2_trip & ~sw_ov2_inh;
  assign next_stage.uv1_start = stage_in.uv1_start & ~uv1_blocked;
  assign next_stage.uv1_trip = stage_in.uv1_trip & ~uv1_blocked &
                               ~(sw_uv1_tripblk & stage_in.uv1_start);
  assign next_stage.uv2_start = uv2_low & ~uv2_blocked & ~sw_uv2_inh;
  assign next_stage.uv2_trip = stage_in.uv2_trip & uv2_low &
                               ~uv2_blocked & ~sw_uv2_inh;

  // One register stage between the raw stage logic and stage_out; each contact channel adds a second
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      stage_out <= '0;
      single_phase_mode <= 1'b0;
      uv2_use_pos_seq <= 1'b0;
    end else begin
      stage_out <= next_stage;
      single_phase_mode <= sw_single;
      uv2_use_pos_seq <= sw_pos_seq;
    end
  end

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  logic [15:0] div_cnt;
  logic ms_tick;

  assign ms_tick = (div_cnt == 16'(MS_DIV - 1));

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= ms_tick ? 16'h0000 : div_cnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Binary unlatch pin synchroniser and filter
  // ----------------------------------------------------------------
  logic [2:0] bin_sync;
  logic bin_level;
  logic bin_level_d;
  logic unlatch_any;

  // Stage 1 feeds stage 2 only; stages 2 and 3 must agree to change level
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      bin_sync <= 3'h0;
      bin_level <= 1'b0;
      bin_level_d <= 1'b0;
    end else begin
      bin_sync <= {bin_sync[1:0], unlatch_binary_pin};
      bin_level <= (bin_sync[1] == bin_sync[2]) ? bin_sync[2] : bin_level;
      bin_level_d <= bin_level;
    end
  end

  assign unlatch_any = unlatch_panel | unlatch_serial |
                       (bin_level & ~bin_level_d);

  // ----------------------------------------------------------------
  // Breaker failure backup controller
  // ----------------------------------------------------------------
  vrf_bk_state_t bk_state;
  vrf_bk_state_t next_bk_state;
  logic [9:0] bk_ms;
  logic [9:0] next_bk_ms;
  logic trip_any;
  logic start_any;

  assign trip_any = stage_out.ov1_trip | stage_out.ov2_trip |
                    stage_out.uv1_trip | stage_out.uv2_trip;
  assign start_any = stage_out.ov1_start | stage_out.ov2_start |
                     stage_out.uv1_start | stage_out.uv2_start;

  // A cleared fault returns to idle from any state
  always_comb begin
    next_bk_state = bk_state;
    next_bk_ms = bk_ms;
    case (bk_state)
      VRF_BK_IDLE: begin
        next_bk_ms = 10'h000;
        if (backup_en && trip_any) begin
          next_bk_state = VRF_BK_TIMING;
        end
      end
      VRF_BK_TIMING: begin
        if (!backup_en || !trip_any) begin
          next_bk_state = VRF_BK_IDLE;
        end else if (bk_ms >= breaker_failure_delay_ms) begin
          next_bk_state = VRF_BK_BACKUP;
        end else if (ms_tick) begin
          next_bk_ms = bk_ms + 10'h001;
        end
      end
      VRF_BK_BACKUP: begin
        if (!backup_en || !trip_any) begin
          next_bk_state = VRF_BK_IDLE;
        end
      end
      default: begin
        next_bk_state = VRF_BK_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      bk_state <= VRF_BK_IDLE;
      bk_ms <= 10'h000;
      breaker_failure_backup <= 1'b0;
    end else begin
      bk_state <= next_bk_state;
      bk_ms <= next_bk_ms;
      breaker_failure_backup <= (next_bk_state == VRF_BK_BACKUP);
    end
  end

  // ----------------------------------------------------------------
  // Output contact channels
  // ----------------------------------------------------------------
  logic [VRF_CHANNELS-1:0] ch_drive;
  logic [VRF_CHANNELS-1:0] ch_latch;
  logic [VRF_CHANNELS-1:0] ch_short;
  logic [VRF_CHANNELS-1:0] ch_out;
  logic pwr_b_drive;

  // With backup on, output b is reserved for the delayed backup trip
  assign pwr_b_drive = backup_en ? (bk_state == VRF_BK_BACKUP) : trip_any;
  // Channel order: power a, power b, signal a, signal b
  assign ch_drive = {trip_any, start_any, pwr_b_drive, trip_any};
  assign ch_latch = {1'b0, 1'b0, latch_b, latch_a};
  assign ch_short = {sig_short, sig_short, pwr_short, pwr_short};

  generate
    for (genvar g = 0; g < VRF_CHANNELS; g++) begin : g_ch
      vrf_out_channel u_ch (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .ms_tick(ms_tick),
        .drive(ch_drive[g]),
        .latch_en(ch_latch[g]),
        .short_sel(ch_short[g]),
        .unlatch(unlatch_any),
        .out(ch_out[g])
      );
    end
  endgenerate

  assign power_output_a = ch_out[0];
  assign power_output_b = ch_out[1];
  assign signal_output_a = ch_out[2];
  assign signal_output_b = ch_out[3];

endmodule : vrf_relay_config

// ===== core/vrf_pkg.sv
/*
  Package for the voltage relay function configuration block: switch
  positions in both switchgroups, reset values, timing constants, the
  stage signal carriers and the controller state encoding.
  Assumes a single 20 MHz system clock shared by every user.
*/
package vrf_pkg;

  // ----------------------------------------------------------------
  // Switchgroup selection and layout
  // ----------------------------------------------------------------
  localparam logic VRF_SEL_OUTPUT = 1'b0;
  localparam logic VRF_SEL_STAGE = 1'b1;
  localparam logic [7:0] VRF_OUTPUT_RESET = 8'h00;
  localparam logic [7:0] VRF_STAGE_RESET = 8'h00;
  // Switches 6..8 of the output group are unused and read as zero
  localparam logic [7:0] VRF_OUTPUT_USED_MASK = 8'h1f;

  // Output function switches, switch n at bit n-1
  localparam int VRF_OF_LATCH_A = 0;
  localparam int VRF_OF_LATCH_B = 1;
  localparam int VRF_OF_SIG_SHORT = 2;
  localparam int VRF_OF_PWR_SHORT = 3;
  localparam int VRF_OF_BACKUP_EN = 4;

  // Stage function switches, switch n at bit n-1
  localparam int VRF_SF_SINGLE_PHASE = 0;
  localparam int VRF_SF_POS_SEQ = 1;
  localparam int VRF_SF_ANY_PHASE = 2;
  localparam int VRF_SF_UV1_NOBLK = 3;
  localparam int VRF_SF_UV2_NOBLK = 4;
  localparam int VRF_SF_OV2_INHIBIT = 5;
  localparam int VRF_SF_UV2_INHIBIT = 6;
  localparam int VRF_SF_UV1_TRIPBLK = 7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int VRF_CLK_HZ = 20000000;
  localparam int VRF_TICK_PER_S = 1000;
  localparam int VRF_MS_DIV = VRF_CLK_HZ / VRF_TICK_PER_S;
  localparam int VRF_PULSE_LONG_MS = 80;
  localparam int VRF_PULSE_SHORT_MS = 40;
  // One extra tick because the first tick may fall right after the load
  localparam logic [6:0] VRF_PULSE_LONG_TICKS = 7'(VRF_PULSE_LONG_MS + 1);
  localparam logic [6:0] VRF_PULSE_SHORT_TICKS = 7'(VRF_PULSE_SHORT_MS + 1);
  localparam int VRF_PHASES = 3;
  localparam int VRF_CHANNELS = 4;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ov1_start;
    logic ov1_trip;
    logic ov2_start;
    logic ov2_trip;
    logic uv1_start;
    logic uv1_trip;
    logic uv2_start;
    logic uv2_trip;
  } vrf_stage_t;

  typedef struct packed {
    logic [VRF_PHASES-1:0] phase_below;
    logic pos_seq_below;
    logic low_voltage;
  } vrf_meas_t;

  typedef enum logic [2:0] {
    VRF_BK_IDLE = 3'b001,
    VRF_BK_TIMING = 3'b010,
    VRF_BK_BACKUP = 3'b100
  } vrf_bk_state_t;

endpackage : vrf_pkg

// ===== core/vrf_out_channel.sv
/*
  One output contact channel: minimum pulse stretcher and optional latch.
  Assumes drive and unlatch come from logic on sys_clk and that ms_tick
  is a one-cycle pulse once per millisecond.
*/
`timescale 1ns/1ps
module vrf_out_channel
  import vrf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ms_tick,
  input wire logic drive,
  input wire logic latch_en,
  input wire logic short_sel,
  input wire logic unlatch,
  output logic out
);

  logic drive_d;
  logic latched;
  logic [6:0] hold;
  logic next_latched;
  logic [6:0] next_hold;
  logic rise;
  logic [6:0] pulse_len;

  // ----------------------------------------------------------------
  // Pulse length and latch decode
  // ----------------------------------------------------------------
  assign rise = drive & ~drive_d;
  assign pulse_len = short_sel ? VRF_PULSE_SHORT_TICKS : VRF_PULSE_LONG_TICKS;
  // Load on the rising drive edge, then count down on millisecond ticks
  assign next_hold = rise ? pulse_len :
                     ((hold != 7'h00) && ms_tick) ? hold - 7'h01 : hold;
  // A new drive wins over a simultaneous unlatch so no trip is lost
  assign next_latched = (drive & latch_en) ? 1'b1 :
                        unlatch ? 1'b0 : latched;

  // Latch outlives the pulse timer, so it overrides the minimum length
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      drive_d <= 1'b0;
      latched <= 1'b0;
      hold <= 7'h00;
      out <= 1'b0;
    end else begin
      drive_d <= drive;
      latched <= next_latched;
      hold <= next_hold;
      out <= drive | (next_hold != 7'h00) | next_latched;
    end
  end

endmodule : vrf_out_channel

// ===== sim/vrf_stage_model.sv
/*
  Model of the protection stage logic that feeds the configuration block.
  Assumes the bench commands start, trip and measurement levels on sys_clk.
*/
`timescale 1ns/1ps
module vrf_stage_model
  import vrf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire vrf_stage_t stage_cmd,
  input wire vrf_meas_t meas_cmd,
  output vrf_stage_t stage_in,
  output vrf_meas_t meas_in
);
  // Stage levels are registered, as real stage logic is; quiet in reset
  // Below flags assume start values set as advised for single-phase and sensitive use
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      stage_in <= '0;
      meas_in <= '0;
    end else begin
      stage_in <= stage_cmd;
      meas_in <= meas_cmd;
    end
  end
endmodule : vrf_stage_model

// ===== sim/vrf_relay_config_sva.sv
/*
  Checker for the relay configuration block: group writes, checksums,
  stage gating, minimum pulse length and breaker failure backup.
  Assumes it is bound to the top module with the same MS_DIV.
*/
`timescale 1ns/1ps
module vrf_relay_config_sva
  import vrf_pkg::*;
#(
  parameter int MS_DIV = VRF_MS_DIV
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic cfg_wr_en,
  input wire logic cfg_wr_sel,
  input wire logic [7:0] cfg_wr_data,
  input wire logic [7:0] output_function_switches,
  input wire logic [7:0] stage_function_switches,
  input wire logic [7:0] output_checksum,
  input wire logic [7:0] stage_checksum,
  input wire vrf_stage_t stage_in,
  input wire vrf_meas_t meas_in,
  input wire vrf_stage_t stage_out,
  input wire logic power_output_b,
  input wire logic signal_output_a,
  input wire logic breaker_failure_backup
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // Helper: length of the current signal pulse in cycles
  // ----------------------------------------------------------------
  logic [31:0] hi_cnt;
  always_ff @(posedge sys_clk) begin
    hi_cnt <= (!nrst || !signal_output_a) ? 32'h0 : hi_cnt + 32'h1;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_wr_output: assert property (
    cfg_wr_en && !cfg_wr_sel |=>
      output_function_switches == ($past(cfg_wr_data) & VRF_OUTPUT_USED_MASK))
    else $error("output group write lost");
  a_wr_stage: assert property (
    cfg_wr_en && cfg_wr_sel |=> stage_function_switches == $past(cfg_wr_data))
    else $error("stage group write lost");
  a_unused_zero: assert property (output_function_switches[7:5] == 3'h0)
    else $error("unused output switches set");
  a_checksum_match: assert property (
    output_checksum == output_function_switches && stage_checksum == stage_function_switches)
    else $error("checksum differs from group");
  a_ov2_inhibit: assert property (
    $past(stage_function_switches[5]) |-> !stage_out.ov2_start && !stage_out.ov2_trip)
    else $error("inhibited overvoltage stage active");
  a_ov2_pass: assert property (
    $past(nrst) && !$past(stage_function_switches[5]) |->
      stage_out.ov2_trip == $past(stage_in.ov2_trip))
    else $error("overvoltage trip not passed");
  a_uv2_inhibit: assert property (
    $past(stage_function_switches[6]) |-> !stage_out.uv2_start && !stage_out.uv2_trip)
    else $error("inhibited undervoltage stage active");
  a_uv1_low_block: assert property (
    $past(meas_in.low_voltage && !stage_function_switches[3]) |->
      !stage_out.uv1_start && !stage_out.uv1_trip)
    else $error("low voltage block missing");
  a_pulse_min: assert property (
    $fell(signal_output_a) |-> hi_cnt >= (output_function_switches[2] ?
      VRF_PULSE_SHORT_MS : VRF_PULSE_LONG_MS) * MS_DIV)
    else $error("signal pulse too short");
  a_backup_off: assert property (!output_function_switches[4] [*2] |->
    !breaker_failure_backup)
    else $error("backup active while disabled");
  a_backup_drive: assert property (breaker_failure_backup |=> power_output_b)
    else $error("backup did not drive output b");
endmodule : vrf_relay_config_sva

bind vrf_relay_config vrf_relay_config_sva #(.MS_DIV(MS_DIV)) sva_u (.sys_clk, .nrst,
  .cfg_wr_en, .cfg_wr_sel, .cfg_wr_data, .output_function_switches,
  .stage_function_switches, .output_checksum, .stage_checksum, .stage_in, .meas_in,
  .stage_out, .power_output_b, .signal_output_a, .breaker_failure_backup);

// ===== sim/vrf_relay_config_tb.sv
/*
  Self-checking bench for the relay configuration block and stage model.
  Assumes a shortened millisecond divider so pulse timing stays brief.
*/
`timescale 1ns/1ps
module vrf_relay_config_tb;
  import vrf_pkg::*;
  localparam int DIV = 8;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic cfg_wr_en = 1'b0;
  logic cfg_wr_sel = 1'b0;
  logic [7:0] cfg_wr_data = 8'h00;
  logic unlatch_panel = 1'b0;
  logic unlatch_serial = 1'b0;
  logic unlatch_binary_pin = 1'b0;
  logic [9:0] breaker_failure_delay_ms = 10'h005;
  vrf_stage_t stage_cmd = '0;
  vrf_meas_t meas_cmd = '0;
  vrf_stage_t stage_in, stage_out;
  vrf_meas_t meas_in;
  logic [7:0] output_function_switches, stage_function_switches;
  logic [7:0] output_checksum, stage_checksum;
  logic single_phase_mode, uv2_use_pos_seq, breaker_failure_backup;
  logic power_output_a, power_output_b, signal_output_a, signal_output_b;
  int bad_count = 0;
  int checked = 0;
  int seed = 51;

  always #25 sys_clk = ~sys_clk;

  vrf_stage_model model_u (.sys_clk, .nrst, .stage_cmd, .meas_cmd, .stage_in, .meas_in);
  vrf_relay_config #(.MS_DIV(DIV)) dut_u (.sys_clk, .nrst, .cfg_wr_en, .cfg_wr_sel,
    .cfg_wr_data, .output_function_switches, .stage_function_switches, .output_checksum,
    .stage_checksum, .unlatch_panel, .unlatch_serial, .unlatch_binary_pin,
    .breaker_failure_delay_ms, .stage_in, .meas_in, .single_phase_mode,
    .uv2_use_pos_seq, .stage_out, .power_output_a, .power_output_b, .signal_output_a,
    .signal_output_b, .breaker_failure_backup);

  // ----------------------------------------------------------------
  // Tasks and expectation functions
  // ----------------------------------------------------------------
  task automatic conclude();
    if (bad_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  // Values are taken at the call, settled a cycle earlier; compare off the edge
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    #1;
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic sel, input logic [7:0] d);
    @(posedge sys_clk);
    cfg_wr_en <= 1'b1;
    cfg_wr_sel <= sel;
    cfg_wr_data <= d;
    @(posedge sys_clk);
    cfg_wr_en <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  // Overvoltage start and trip together, as a real stage raises them
  task automatic fault(input int n);
    @(posedge sys_clk);
    stage_cmd <= vrf_stage_t'(8'hc0);
    repeat (n) @(posedge sys_clk);
    stage_cmd <= '0;
  endtask : fault

  // Bounded wait for every contact to drop after a pulse
  task automatic quiet();
    for (int k = 0; k < 200 * DIV; k++) begin
      @(posedge sys_clk);
      if ((power_output_a | power_output_b | signal_output_a | signal_output_b) === 1'b0)
        break;
    end
  endtask : quiet

  function automatic logic [7:0] wsum(input logic [7:0] v);
    int t;
    t = 0;
    for (int b = 0; b < 8; b++) t += v[b] * (1 << b);
    return 8'(t);
  endfunction : wsum

  function automatic logic [7:0] in_rng(input int n, input int ms);
    return {7'h0, n >= ms * DIV && n <= (ms + 2) * DIV + 4};
  endfunction : in_rng

  function automatic vrf_stage_t exp_stage(input logic [7:0] w, input vrf_stage_t s,
      input vrf_meas_t m);
    vrf_stage_t e;
    logic b1;
    logic b2;
    logic c;
    b1 = m.low_voltage & ~w[3];
    b2 = m.low_voltage & ~w[4];
    c = w[1] ? m.pos_seq_below : (w[0] ? m.phase_below[0] :
        (w[2] ? |m.phase_below : &m.phase_below));
    e = s;
    e.ov2_start = s.ov2_start & ~w[5];
    e.ov2_trip = s.ov2_trip & ~w[5];
    e.uv1_start = s.uv1_start & ~b1;
    e.uv1_trip = s.uv1_trip & ~b1 & ~(w[7] & s.uv1_start);
    e.uv2_start = c & ~b2 & ~w[6];
    e.uv2_trip = s.uv2_trip & e.uv2_start;
    return e;
  endfunction : exp_stage

  // ----------------------------------------------------------------
  // Watchdog, well beyond the roughly 6400 cycles the tests take
  // ----------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int i;
    int n_p;
    int n_s;
    logic [7:0] d;
    logic [7:0] m;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    chk("output_group", 8'h00, output_function_switches);
    chk("stage_group", 8'h00, stage_function_switches);
    // Random group writes; all-ones first shows the unused switches dropped
    for (i = 0; i < 24; i++) begin
      d = (i < 2) ? 8'hff : 8'($random(seed));
      wr(i[0], d);
      chk("group", i[0] ? d : d & 8'h1f, i[0] ? stage_function_switches :
        output_function_switches);
      chk("checksum", wsum(i[0] ? d : d & 8'h1f), i[0] ? stage_checksum :
        output_checksum);
    end
    wr(1'b0, 8'h00);
    // Stage gating under random switches and levels, trip-block included
    for (i = 0; i < 24; i++) begin
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
      wr(1'b1, d);
      stage_cmd <= vrf_stage_t'(8'($random(seed)));
      meas_cmd <= vrf_meas_t'(5'($random(seed)));
      repeat (3) @(posedge sys_clk);
      m = exp_stage(d, stage_cmd, meas_cmd);
      chk("stage_out", m, stage_out);
      chk("phase_mode", {7'h0, d[0]}, {7'h0, single_phase_mode});
      chk("pos_seq_mode", {7'h0, d[1]}, {7'h0, uv2_use_pos_seq});
    end
    @(posedge sys_clk);
    stage_cmd <= '0;
    meas_cmd <= '0;
    wr(1'b1, 8'h00);
    quiet();
    // Minimum pulse for every short and long combination
    for (i = 0; i < 4; i++) begin
      wr(1'b0, 8'(i << 2));
      fault(1);
      n_p = 0;
      n_s = 0;
      for (int k = 0; k < 100 * DIV; k++) begin
        @(posedge sys_clk);
        #1;
        n_p += int'(power_output_a);
        n_s += int'(signal_output_b);
        if (n_p > 0 && power_output_a === 1'b0 && signal_output_b === 1'b0) break;
      end
      chk("power_pulse", 8'h01, in_rng(n_p, i[1] ? 40 : 80));
      chk("signal_pulse", 8'h01, in_rng(n_s, i[0] ? 40 : 80));
    end
    // Latched outputs outlast the pulse and yield to each unlatch source
    wr(1'b0, 8'h0b);
    for (i = 0; i < 3; i++) begin
      fault(1);
      repeat (100 * DIV) @(posedge sys_clk);
      chk("latched", 8'h03, {6'h0, power_output_a, power_output_b});
      @(posedge sys_clk);
      unlatch_panel <= (i == 0);
      unlatch_binary_pin <= (i == 1);
      unlatch_serial <= (i == 2);
      repeat (10) @(posedge sys_clk);
      unlatch_panel <= 1'b0;
      unlatch_binary_pin <= 1'b0;
      unlatch_serial <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk("unlatched", 8'h00, {6'h0, power_output_a, power_output_b});
    end
    // Breaker failure backup: held fault, then a fault cleared in time
    wr(1'b0, 8'h10);
    @(posedge sys_clk);
    stage_cmd <= vrf_stage_t'(8'hc0);
    repeat (2 * DIV) @(posedge sys_clk);
    chk("backup_early", 8'h00, {6'h0, breaker_failure_backup, power_output_b});
    repeat (7 * DIV) @(posedge sys_clk);
    chk("backup_late", 8'h03, {6'h0, breaker_failure_backup, power_output_b});
    @(posedge sys_clk);
    stage_cmd <= '0;
    quiet();
    fault(2 * DIV);
    repeat (10 * DIV) @(posedge sys_clk);
    chk("backup_clear", 8'h00, {6'h0, breaker_failure_backup, power_output_b});
    conclude();
  end
endmodule : vrf_relay_config_tb
